/* File: logic/fsp_pkg.sv */
// Purpose: Shared constants and types for the flash sector protect host controller
// Assumes: 40 MHz system clock; the flash is driven through its control and address pins
// Notes:   High-voltage select is a pin-level request to an external 12 V switch
package fsp_pkg;

	localparam int unsigned CLK_HZ         = 40_000_000;
	// Protect pulse width, least 100 ns, typical 10 us
	localparam int unsigned PROT_PULSE_NS  = 10_000;
	// Chip unprotect pulse width, least 100 ns, typical 12 ms
	localparam int unsigned UNPROT_PULSE_NS = 12_000_000;
	// Setup and hold around write-enable, least 100 ns
	localparam int unsigned SETUP_NS       = 100;
	// Read access time, longest 90 ns
	localparam int unsigned ACCESS_NS      = 90;
	localparam int unsigned PROT_PULSE_CYC   = (PROT_PULSE_NS * 40 + 999) / 1000;
	localparam int unsigned UNPROT_PULSE_CYC = (UNPROT_PULSE_NS / 1000) * (CLK_HZ / 1_000_000);
	localparam int unsigned SETUP_CYC      = (SETUP_NS * 40 + 999) / 1000;
	localparam int unsigned ACCESS_CYC     = (ACCESS_NS * 40 + 999) / 1000 + 3;

	localparam int unsigned ADDR_W         = 19;
	localparam int unsigned ADDR_BIT_ZERO  = 0;
	localparam int unsigned ADDR_BIT_ONE   = 1;
	localparam int unsigned ADDR_BIT_SIX   = 6;
	localparam int unsigned DATA_OUT_BIT_ZERO = 0;
	localparam logic [7:0]  UNPROT_CODE    = 8'h00;

	typedef enum logic [1:0]
	{
		FSP_CMD_PROTECT,
		FSP_CMD_VERIFY,
		FSP_CMD_UNPROTECT
	} fsp_cmd_t;

	// Pin drive set toward the flash
	typedef struct packed
	{
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              hv_address_line_nine;
		logic              hv_oe;
		logic [ADDR_W-1:0] addr;
	} fsp_pins_t;

	// Result returned to the user
	typedef struct packed
	{
		logic       is_protected;
		logic       bad_code;
		logic [7:0] raw;
	} fsp_result_t;

endpackage : fsp_pkg

/* File: logic/fsp_sync.sv */
// Purpose: Two-flop synchroniser for a bus of pin inputs
// Assumes: Inputs are asynchronous to i_sys_clk
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
module fsp_sync #(
	parameter int unsigned W = 8
) (
	// Clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst_n,
	// Data
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_r;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			meta_r <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule : fsp_sync

/* File: logic/fsp_host.sv */
// Purpose: Host controller running protect, verify and chip unprotect on a flash
// Assumes: External switches raise the flash pins to the high-voltage level on request
// Notes:   One command at a time; o_busy stays high until o_done pulses
//
// Functional notes
// R1 - Flash refuses program and erase on protected sectors.
// R2 - Protect needs high voltage on address line nine and output-enable.
// R3 - Protect write lasts from write-enable fall to its rise.
// R4 - Verify: high voltage on line nine, chip and output enable low, write high.
// R5 - Verify with bit one high, bits zero and six low gives bit zero.
// R6 - Verify ignores other address bits; bit one low reads identifier codes.
// R7 - After identifier-read command, bit one high reads bit zero protection.
// R8 - Unprotect: high voltage on output-enable and line nine, chip low, bit six high.
// R9 - Unprotect clears from write-enable fall to rise; all marks then cleared.
// R10 - Identifier read of an unprotected sector returns all zeros.
// R11 - Protecting every sector first is recommended, not required.
// R12 - High voltage on reset pin lifts protection temporarily.
// R13 - Each sector keeps a nonvolatile mark changed only by these sequences.
`timescale 1ns/1ps
module fsp_host
	import fsp_pkg::*;
#(
	parameter int unsigned PROT_CYC   = PROT_PULSE_CYC,
	parameter int unsigned UNPROT_CYC = UNPROT_PULSE_CYC
) (
	// Clock and reset
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst_n,
	// User command port
	input  wire logic                   i_start,
	input  wire fsp_pkg::fsp_cmd_t      i_cmd,
	input  wire logic [fsp_pkg::ADDR_W-1:0] i_sector_addr,
	output logic                        o_busy,
	output logic                        o_done,
	output fsp_pkg::fsp_result_t        o_result,
	// Flash pins
	output fsp_pkg::fsp_pins_t          o_pins,
	input  wire logic [7:0]             i_flash_dq
);
	import fsp_pkg::*;

	typedef enum
	{
		ST_IDLE,
		ST_SETUP,
		ST_PULSE,
		ST_HOLD,
		ST_READ,
		ST_DONE
	} fsp_state_t;

	localparam int unsigned CNT_W = 32;

	fsp_state_t        state_r;
	fsp_cmd_t          cmd_r;
	logic [CNT_W-1:0]  cnt_r;
	logic [7:0]        dq_sync;

	fsp_sync #(
		.W (8)
	) u_dq_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_flash_dq),
		.o_sync    (dq_sync)
	);

	// Sequencer and timing counter
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			state_r <= ST_IDLE;
			cmd_r   <= FSP_CMD_VERIFY;
			cnt_r   <= '0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (i_start)
					begin
						cmd_r   <= i_cmd;
						cnt_r   <= CNT_W'(SETUP_CYC);
						state_r <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					if (cnt_r > 1)
						cnt_r <= cnt_r - 1'b1;
					else if (cmd_r == FSP_CMD_VERIFY)
					begin
						cnt_r   <= CNT_W'(ACCESS_CYC);
						state_r <= ST_READ;
					end
					else
					begin
						cnt_r   <= (cmd_r == FSP_CMD_PROTECT) ? CNT_W'(PROT_CYC)
							: CNT_W'(UNPROT_CYC);
						state_r <= ST_PULSE;
					end
				end
				ST_PULSE:
				begin
					if (cnt_r > 1)
						cnt_r <= cnt_r - 1'b1;
					else
					begin
						cnt_r   <= CNT_W'(SETUP_CYC);
						state_r <= ST_HOLD;
					end
				end
				ST_HOLD:
				begin
					if (cnt_r > 1)
						cnt_r <= cnt_r - 1'b1;
					else
						state_r <= ST_DONE;
				end
				ST_READ:
				begin
					if (cnt_r > 1)
						cnt_r <= cnt_r - 1'b1;
					else
						state_r <= ST_DONE;
				end
				ST_DONE:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Pin drive, all from flops
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, hv_address_line_nine: 1'b0,
				hv_oe: 1'b0, addr: '0};
		end
		else if (state_r == ST_IDLE && i_start)
		begin
			o_pins.ce_n                 <= 1'b0;
			o_pins.we_n                 <= 1'b1;
			o_pins.hv_address_line_nine <= 1'b1;
			o_pins.addr                 <= i_sector_addr;
			case (i_cmd)
				// R2 protect levels
				FSP_CMD_PROTECT:
				begin
					o_pins.hv_oe <= 1'b1;
					o_pins.oe_n  <= 1'b1;
					// Bit six low, else a protect would clear every mark
					o_pins.addr[ADDR_BIT_SIX]   <= 1'b0;
				end
				// R8 unprotect levels, bit six high
				// R11 no forced protect-all pass; caller's choice
				FSP_CMD_UNPROTECT:
				begin
					o_pins.hv_oe                <= 1'b1;
					o_pins.oe_n                 <= 1'b1;
					o_pins.addr[ADDR_BIT_SIX]   <= 1'b1;
				end
				// R4 R5 verify levels: bit one high, bits zero and six low
				default:
				begin
					o_pins.hv_oe                <= 1'b0;
					o_pins.oe_n                 <= 1'b0;
					o_pins.addr[ADDR_BIT_ONE]   <= 1'b1;
					o_pins.addr[ADDR_BIT_ZERO]  <= 1'b0;
					o_pins.addr[ADDR_BIT_SIX]   <= 1'b0;
				end
			endcase
		end
		// R3 R9 write-enable low frames the mark write or clear
		else if (state_r == ST_SETUP && cnt_r <= 1 && cmd_r != FSP_CMD_VERIFY)
			o_pins.we_n <= 1'b0;
		else if (state_r == ST_PULSE && cnt_r <= 1)
			o_pins.we_n <= 1'b1;
		else if (state_r == ST_DONE)
		begin
			o_pins.ce_n                 <= 1'b1;
			o_pins.oe_n                 <= 1'b1;
			o_pins.we_n                 <= 1'b1;
			o_pins.hv_address_line_nine <= 1'b0;
			o_pins.hv_oe                <= 1'b0;
		end
	end

	// Status and result
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_busy   <= 1'b0;
			o_done   <= 1'b0;
			o_result <= '0;
		end
		else
		begin
			o_done <= (state_r == ST_DONE);
			if (state_r == ST_IDLE && i_start)
				o_busy <= 1'b1;
			else if (state_r == ST_DONE)
				o_busy <= 1'b0;
			// R5 R10 only 01h or 00h are legal answers
			if (state_r == ST_READ && cnt_r <= 1)
			begin
				o_result.raw          <= dq_sync;
				o_result.is_protected <= dq_sync[DATA_OUT_BIT_ZERO];
				o_result.bad_code     <= (dq_sync[7:1] != UNPROT_CODE[7:1]);
			end
		end
	end

	// Assertions
	sequence s_we_low;
		!o_pins.we_n;
	endsequence

	property p_hv_during_write;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_we_low |-> (o_pins.hv_address_line_nine && o_pins.hv_oe && !o_pins.ce_n);
	endproperty
	a_hv_during_write: assert property (p_hv_during_write) // R2
		else $error("write pulse without high-voltage levels");

	property p_unprot_bit_six;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(s_we_low and cmd_r == FSP_CMD_UNPROTECT) |-> o_pins.addr[ADDR_BIT_SIX];
	endproperty
	a_unprot_bit_six: assert property (p_unprot_bit_six) // R8
		else $error("unprotect pulse without address bit six high");

	property p_verify_levels;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r == ST_READ) |-> (!o_pins.ce_n && !o_pins.oe_n && o_pins.we_n
			&& o_pins.hv_address_line_nine && !o_pins.hv_oe);
	endproperty
	a_verify_levels: assert property (p_verify_levels) // R4
		else $error("verify read with wrong control levels");

	property p_verify_addr;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r == ST_READ) |-> (o_pins.addr[ADDR_BIT_ONE] && !o_pins.addr[ADDR_BIT_ZERO]
			&& !o_pins.addr[ADDR_BIT_SIX]);
	endproperty
	a_verify_addr: assert property (p_verify_addr) // R5
		else $error("verify read address bits wrong");

	property p_we_rises;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		$fell(o_pins.we_n) && cmd_r == FSP_CMD_PROTECT |-> ##[1:1000] $rose(o_pins.we_n);
	endproperty
	a_we_rises: assert property (p_we_rises) // R3
		else $error("protect pulse did not end");

	property p_done_ends_busy;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_done |-> !o_busy && o_pins.ce_n && !o_pins.hv_address_line_nine;
	endproperty
	a_done_ends_busy: assert property (p_done_ends_busy) // done drops busy and releases chip enable and line nine
		else $error("done without release of pins");

endmodule : fsp_host

/* File: testbench/fsp_flash_model.sv */
// Purpose: Behavioural flash seen by the host: sector marks, verify read
// Assumes: Sector index in address bits SEC_LSB upward, eight sectors
// Notes:   Zero access delay; released data shows inverse of last value
`timescale 1ns/1ps
module fsp_flash_model
	import fsp_pkg::*;
#(
	parameter int unsigned SEC_LSB = 16,
	// Arbitrary identifier value
	parameter logic [7:0]  ID_CODE = 8'h5a
) (
	// Pins from host
	input  wire fsp_pkg::fsp_pins_t i_pins,
	// Data toward host
	output logic [7:0]              o_dq
);
	logic [7:0] marks_r = 8'h00;
	logic [7:0] last_r  = 8'h00;
	logic [7:0] val;
	logic       rd;
	wire  [2:0] sec = i_pins.addr[SEC_LSB+:3];
	assign rd = i_pins.hv_address_line_nine && !i_pins.hv_oe && !i_pins.ce_n
		&& !i_pins.oe_n && i_pins.we_n;
	assign val = i_pins.addr[1] ? {7'h00, marks_r[sec]} : ID_CODE;
	assign o_dq = rd ? val : ~last_r;
	always @*
		if (rd)
			last_r = val;
	// marks change on write-enable rise only
	always @(posedge i_pins.we_n)
		if (i_pins.hv_address_line_nine && i_pins.hv_oe && !i_pins.ce_n)
			if (i_pins.addr[6])
				marks_r = 8'h00;
			else
				marks_r[sec] = 1'b1;
endmodule : fsp_flash_model

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the sector protect host
// Assumes: Short pulse counts 4 and 8 cycles
// Notes:   Each command also gets a refused start poke while busy
`timescale 1ns/1ps
module tb_top;
	import fsp_pkg::*;
	localparam int unsigned PC = 4;
	localparam int unsigned UC = 8;
	logic                i_sys_clk = 1'b0;
	logic                i_rst_n   = 1'b0;
	logic                i_start   = 1'b0;
	fsp_cmd_t            i_cmd     = FSP_CMD_VERIFY;
	logic [ADDR_W-1:0]   i_sector_addr = '0;
	logic                o_busy;
	logic                o_done;
	fsp_result_t         o_result;
	fsp_pins_t           o_pins;
	logic [7:0]          dq;
	int                  n_errors = 0;
	int                  samples_checked = 0;
	int                  lo_n;
	int                  rd_n;
	logic                bz_ok;
	logic                hv_ok;
	logic                rd_ok;
	logic                a6;
	always #12.5 i_sys_clk = ~i_sys_clk;
	fsp_host #(.PROT_CYC(PC), .UNPROT_CYC(UC)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_start(i_start), .i_cmd(i_cmd), .i_sector_addr(i_sector_addr), .o_busy(o_busy),
		.o_done(o_done), .o_result(o_result), .o_pins(o_pins), .i_flash_dq(dq));
	fsp_flash_model flash (.i_pins(o_pins), .o_dq(dq));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task end_of_test;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task run(input fsp_cmd_t c, input logic [ADDR_W-1:0] a);
		int k;
		@(posedge i_sys_clk);
		i_start <= 1'b1;
		i_cmd <= c;
		i_sector_addr <= a;
		@(posedge i_sys_clk);
		i_start <= 1'b0;
		lo_n = 0;
		rd_n = 0;
		{hv_ok, rd_ok, bz_ok, a6} = 4'he;
		for (k = 0; k < 2000 && o_done !== 1'b1; k++)
		begin
			@(posedge i_sys_clk);
			// Busy start must be ignored
			i_start <= (k == 3);
			i_cmd <= (k == 3) ? FSP_CMD_UNPROTECT : c;
			#1;
			if (o_pins.we_n === 1'b0)
			begin
				lo_n++;
				a6 = o_pins.addr[6];
				hv_ok &= o_pins.hv_address_line_nine && o_pins.hv_oe && !o_pins.ce_n;
			end
			if (o_pins.oe_n === 1'b0)
			begin
				rd_n++;
				rd_ok &= o_pins.hv_address_line_nine && !o_pins.hv_oe && !o_pins.ce_n
					&& o_pins.we_n && o_pins.addr[1] && !o_pins.addr[0] && !o_pins.addr[6];
			end
			// Busy up until the done pulse, down with it
			bz_ok &= (o_busy === (o_done !== 1'b1));
		end
		if (k == 2000)
		begin
			n_errors++;
			$display("ERROR timeout waiting for done");
			end_of_test();
		end
		chk("busy frame", bz_ok, 1);
	endtask : run
	task vfy(input logic [ADDR_W-1:0] a, input logic p);
		run(FSP_CMD_VERIFY, a);
		chk("verify pins", rd_ok && rd_n > 0, 1);
		chk("verify read frame", rd_n, SETUP_CYC + ACCESS_CYC);
		chk("verify write idle", lo_n, 0);
		chk("raw", o_result.raw, {7'h00, p});
		chk("is_protected", o_result.is_protected, p);
		chk("bad_code", o_result.bad_code, 0);
	endtask : vfy
	task t_reset;
		chk("idle pins", {o_pins.ce_n, o_pins.oe_n, o_pins.we_n}, 3'h7);
		chk("idle hv", {o_pins.hv_address_line_nine, o_pins.hv_oe, o_busy}, 0);
	endtask : t_reset
	task t_protect;
		// Bits zero and six set here must be overridden
		vfy(19'h2_0041, 1'b0);
		// Bit six set here must be driven low
		run(FSP_CMD_PROTECT, 19'h2_0040);
		chk("protect pulse", lo_n, PC);
		chk("protect hv", {hv_ok, a6}, 2'h2);
		vfy(19'h2_0000, 1'b1);
		vfy(19'h5_0000, 1'b0);
	endtask : t_protect
	task t_unprotect;
		// Only one sector marked before clearing
		run(FSP_CMD_UNPROTECT, 19'h0_0000);
		chk("unprotect pulse", lo_n, UC);
		chk("unprotect hv", {hv_ok, a6}, 2'h3);
		vfy(19'h2_0000, 1'b0);
	endtask : t_unprotect
	initial
	begin
		repeat (20) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		#1;
		t_reset();
		t_protect();
		t_unprotect();
		end_of_test();
	end
endmodule : tb_top
